// ### core/pasl_strap_led.sv
// design: address strap sampling and status led drive on three shared pins
`timescale 1ns/1ps
//------------------------------------------------------------
// Behaviour
// - link pin level during hardware reset sets address bit 2
// - transmit pin level during reset sets address bit 3
// - receive pin level during reset sets address bit 4
// - low sampled gives address bit zero, high gives one
// - after reset link pin asserted while link valid
// - after reset transmit pin asserted during transmit activity
// - after reset receive pin shows receive activity
// - pins sampled on leaving reset, then switch to outputs
// - asserted output level is inverse of the sampled strap level
// - software reset neither resamples nor releases the pins
//------------------------------------------------------------
module pasl_strap_led
(
   input  wire logic       i_mclk,
   input  wire logic       i_rst_b,
   input  wire logic       i_sw_reset,
   input  wire logic       i_link_ok,
   input  wire logic       i_tx_active,
   input  wire logic       i_rx_active,
   input  wire logic       i_addr2_link_led_pin,
   input  wire logic       i_addr3_tx_led_pin,
   input  wire logic       i_addr4_rx_led_pin,
   output logic            o_addr2_link_led_pin,
   output logic            o_addr2_link_led_pin_oe_b,
   output logic            o_addr3_tx_led_pin,
   output logic            o_addr3_tx_led_pin_oe_b,
   output logic            o_addr4_rx_led_pin,
   output logic            o_addr4_rx_led_pin_oe_b,
   output logic [4:0]      o_phy_addr_hi,
   output logic            o_strap_valid
);

   pasl_pkg::pasl_state_t s_q;
   pasl_pkg::pasl_state_t s_d;
   logic [2:0]            pin_in;
   logic [2:0]            status;

   assign pin_in = {i_addr4_rx_led_pin, i_addr3_tx_led_pin, i_addr2_link_led_pin};
   assign status = {i_rx_active, i_tx_active, i_link_ok};

   //------------------------------------------------------------
   // led level
   //------------------------------------------------------------
   // active drives the inverse of the strap, so the led in series
   // with the pull resistor lights whichever way the pin was strapped
   function automatic logic [pasl_pkg::STRAP_N-1:0] led_level
   (
      input logic [pasl_pkg::STRAP_N-1:0] act,
      input logic [pasl_pkg::STRAP_N-1:0] strap
   );
      led_level = act ^ strap;
   endfunction

   //------------------------------------------------------------
   // next state
   //------------------------------------------------------------
   always_comb
   begin
      s_d = s_q;
      unique case (s_q.mode)
         pasl_pkg::PASL_SAMPLE:
         begin
            // first edge after release: the pins still carry the strap level
            s_d.strap = pin_in;
            s_d.oe_b  = 3'h0;
            // first drive cycle shows every led asserted; status counts from the next edge
            s_d.out   = led_level({pasl_pkg::STRAP_N{1'b1}}, pin_in);
            s_d.mode  = pasl_pkg::PASL_DRIVE;
         end
         pasl_pkg::PASL_DRIVE:
         begin
            // software reset ignored here on purpose: straps stay, pins keep driving
            s_d.out  = led_level(status, s_q.strap);
            s_d.oe_b = 3'h0;
         end
      endcase
   end

   //------------------------------------------------------------
   // state register
   //------------------------------------------------------------
   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_b)
      begin
         s_q.mode  <= pasl_pkg::PASL_SAMPLE;
         s_q.strap <= pasl_pkg::STRAP_RST;
         s_q.out   <= pasl_pkg::OUT_RST;
         s_q.oe_b  <= pasl_pkg::OE_B_RST;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   //------------------------------------------------------------
   // outputs
   //------------------------------------------------------------
   assign o_addr2_link_led_pin      = s_q.out[pasl_pkg::LINK_IDX];
   assign o_addr3_tx_led_pin        = s_q.out[pasl_pkg::TX_IDX];
   assign o_addr4_rx_led_pin        = s_q.out[pasl_pkg::RX_IDX];
   // oe_b low while the pin drives its led, high while it is a strap input
   assign o_addr2_link_led_pin_oe_b = s_q.oe_b[pasl_pkg::LINK_IDX];
   assign o_addr3_tx_led_pin_oe_b   = s_q.oe_b[pasl_pkg::TX_IDX];
   assign o_addr4_rx_led_pin_oe_b   = s_q.oe_b[pasl_pkg::RX_IDX];
   // bits 1:0 belong to other pins, reported as zero here
   assign o_phy_addr_hi  = {s_q.strap, 2'h0};
   assign o_strap_valid  = (s_q.mode == pasl_pkg::PASL_DRIVE);

   //------------------------------------------------------------
   // checks
   //------------------------------------------------------------
   // reset term is sampled, so the release edge, where the registers still reset, is left out
   a_link_strap_bit: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      (i_rst_b && s_q.mode == pasl_pkg::PASL_SAMPLE) |=> o_phy_addr_hi[2] == $past(i_addr2_link_led_pin))
      else $error("link strap not captured into address bit 2");

   a_tx_strap_bit: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      (i_rst_b && s_q.mode == pasl_pkg::PASL_SAMPLE) |=> o_phy_addr_hi[3] == $past(i_addr3_tx_led_pin))
      else $error("tx strap not captured into address bit 3");

   a_rx_strap_bit: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      (i_rst_b && s_q.mode == pasl_pkg::PASL_SAMPLE) |=> o_phy_addr_hi[4] == $past(i_addr4_rx_led_pin))
      else $error("rx strap not captured into address bit 4");

   a_link_led_on: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      o_strap_valid ##1 o_strap_valid |-> o_addr2_link_led_pin == ($past(i_link_ok) ^ o_phy_addr_hi[2]))
      else $error("link led level wrong");

   a_tx_led_on: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      o_strap_valid ##1 o_strap_valid |-> o_addr3_tx_led_pin == ($past(i_tx_active) ^ o_phy_addr_hi[3]))
      else $error("tx led level wrong");

   a_rx_led_on: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      o_strap_valid ##1 o_strap_valid |-> o_addr4_rx_led_pin == ($past(i_rx_active) ^ o_phy_addr_hi[4]))
      else $error("rx led level wrong");

   a_pins_released: assert property (@(posedge i_mclk)
      $rose(i_rst_b) |-> ##1 (o_addr2_link_led_pin_oe_b == 1'b0 && o_addr3_tx_led_pin_oe_b == 1'b0 &&
                              o_addr4_rx_led_pin_oe_b == 1'b0))
      else $error("pins not driven one edge after reset release");

   a_sw_reset_keep: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      o_strap_valid && i_sw_reset |=> o_strap_valid && o_addr3_tx_led_pin_oe_b == 1'b0)
      else $error("software reset disturbed strap pins");

   a_addr_stable: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      o_strap_valid |=> $stable(o_phy_addr_hi))
      else $error("sampled address changed without hardware reset");

   a_strap_pins_ignored: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      o_strap_valid && $changed(pin_in) |=> $stable(o_phy_addr_hi))
      else $error("pin level after sampling reached the address");

   //------------------------------------------------------------
   // checks while hardware reset holds the pins as inputs, and one edge after its release
   //------------------------------------------------------------
   a_pins_input_reset: assert property (@(posedge i_mclk)
      !i_rst_b |=> o_addr2_link_led_pin_oe_b && o_addr3_tx_led_pin_oe_b && o_addr4_rx_led_pin_oe_b)
      else $error("strap pins not turned to inputs during hardware reset");

   a_valid_low_reset: assert property (@(posedge i_mclk)
      !i_rst_b |=> !o_strap_valid)
      else $error("strap valid high during hardware reset");

   a_addr_clear_reset: assert property (@(posedge i_mclk)
      !i_rst_b |=> o_phy_addr_hi == 5'h00)
      else $error("address not cleared by hardware reset");

   a_leds_dark_reset: assert property (@(posedge i_mclk)
      !i_rst_b |=> !(o_addr2_link_led_pin || o_addr3_tx_led_pin || o_addr4_rx_led_pin))
      else $error("led drive value not cleared during hardware reset");

   a_valid_after_release: assert property (@(posedge i_mclk)
      $rose(i_rst_b) |-> ##1 o_strap_valid)
      else $error("strap valid not raised one edge after reset release");

   //------------------------------------------------------------
   // checks on the first drive cycle and beyond
   //------------------------------------------------------------
   // the first drive cycle shows every led asserted, whatever the status
   a_link_first_level: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      (i_rst_b && s_q.mode == pasl_pkg::PASL_SAMPLE) |=> o_addr2_link_led_pin == !$past(i_addr2_link_led_pin))
      else $error("link led first level not inverse of its strap");

   a_tx_first_level: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      (i_rst_b && s_q.mode == pasl_pkg::PASL_SAMPLE) |=> o_addr3_tx_led_pin == !$past(i_addr3_tx_led_pin))
      else $error("tx led first level not inverse of its strap");

   a_rx_first_level: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      (i_rst_b && s_q.mode == pasl_pkg::PASL_SAMPLE) |=> o_addr4_rx_led_pin == !$past(i_addr4_rx_led_pin))
      else $error("rx led first level not inverse of its strap");

   a_drive_held: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      o_strap_valid |=> o_strap_valid)
      else $error("pins left drive mode without hardware reset");

   a_oe_low_driving: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      o_strap_valid |-> !(o_addr2_link_led_pin_oe_b || o_addr3_tx_led_pin_oe_b || o_addr4_rx_led_pin_oe_b))
      else $error("a strap pin stopped driving after sampling");

   a_sw_reset_addr: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      o_strap_valid && i_sw_reset |=> $stable(o_phy_addr_hi))
      else $error("software reset changed the sampled address");

   // idle status shows the strap level, so the leds stay dark
   a_leds_idle_level: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      o_strap_valid ##1 (o_strap_valid && $past(status) == 3'h0) |->
         {o_addr4_rx_led_pin, o_addr3_tx_led_pin, o_addr2_link_led_pin}
            == o_phy_addr_hi[pasl_pkg::RX_ADDR_BIT:pasl_pkg::LINK_ADDR_BIT])
      else $error("idle led level differs from the strap level");

   a_leds_busy_level: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      o_strap_valid ##1 (o_strap_valid && $past(status) == 3'h7) |->
         {o_addr4_rx_led_pin, o_addr3_tx_led_pin, o_addr2_link_led_pin}
            == ~o_phy_addr_hi[pasl_pkg::RX_ADDR_BIT:pasl_pkg::LINK_ADDR_BIT])
      else $error("active led level not the inverse of the strap level");

endmodule

// ### pkg/pasl_pkg.sv
// package: constants for the address strap / status led pins
package pasl_pkg;
   localparam int unsigned ADDR_W        = 5;
   localparam int unsigned STRAP_N       = 3;
   // address bit carried by each strap pin
   localparam int unsigned LINK_ADDR_BIT = 2;
   localparam int unsigned TX_ADDR_BIT   = 3;
   localparam int unsigned RX_ADDR_BIT   = 4;
   // position of each pin inside the strap vector
   localparam int unsigned LINK_IDX      = 0;
   localparam int unsigned TX_IDX        = 1;
   localparam int unsigned RX_IDX        = 2;
   localparam logic [2:0]  STRAP_RST     = 3'h0;
   localparam logic [2:0]  OE_B_RST      = 3'h7;
   localparam logic [2:0]  OUT_RST       = 3'h0;

   typedef enum logic [0:0] {PASL_SAMPLE, PASL_DRIVE} pasl_mode_t;

   typedef struct packed {
      pasl_mode_t  mode;
      logic [2:0]  strap;
      logic [2:0]  out;
      logic [2:0]  oe_b;
   } pasl_state_t;
endpackage

// ### verification/pasl_board.sv
// board model: strap pull resistors with series leds on the three shared pins
`timescale 1ns/1ps
module pasl_board
(
   input  wire logic [2:0] i_strap,
   input  wire logic [2:0] i_drv,
   input  wire logic [2:0] i_oe_b,
   output logic [2:0]      o_wire
);
   // a released pin settles to its pull level, never to the last driven value
   assign o_wire = (i_drv & ~i_oe_b) | (i_strap & i_oe_b);
endmodule

// ### verification/tb.sv
// testbench: strap sampling and led drive of the shared pins
`timescale 1ns/1ps
module tb;
   logic i_mclk = 1'b0, i_rst_b = 1'b0, i_sw_reset = 1'b0;
   logic [2:0] stat = 3'h0, strap = 3'h0, wire_lvl, drv, oe_b;
   logic [4:0] addr;
   logic       valid;
   int         fail_count = 0, compares = 0;
   // row: strap, status, expected address, expected led drive
   logic [13:0] rows [4] = '{{3'h0, 3'h7, 5'h00, 3'h7}, {3'h7, 3'h0, 5'h1C, 3'h7},
                             {3'h5, 3'h3, 5'h14, 3'h6}, {3'h2, 3'h6, 5'h08, 3'h4}};
   initial forever #12.5 i_mclk = ~i_mclk;
   pasl_board pasl_board_inst (.i_strap(strap), .i_drv(drv), .i_oe_b(oe_b), .o_wire(wire_lvl));
   pasl_strap_led pasl_strap_led_inst (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_sw_reset(i_sw_reset),
      .i_link_ok(stat[0]), .i_tx_active(stat[1]), .i_rx_active(stat[2]),
      .i_addr2_link_led_pin(wire_lvl[0]), .i_addr3_tx_led_pin(wire_lvl[1]), .i_addr4_rx_led_pin(wire_lvl[2]),
      .o_addr2_link_led_pin(drv[0]), .o_addr2_link_led_pin_oe_b(oe_b[0]),
      .o_addr3_tx_led_pin(drv[1]), .o_addr3_tx_led_pin_oe_b(oe_b[1]),
      .o_addr4_rx_led_pin(drv[2]), .o_addr4_rx_led_pin_oe_b(oe_b[2]),
      .o_phy_addr_hi(addr), .o_strap_valid(valid));
   task automatic chk(input string nm, input logic [4:0] seen, input logic [4:0] exp);
      compares++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic hw_reset(input logic [2:0] s, input int n);
      @(posedge i_mclk) i_rst_b <= 1'b0;
      strap <= s;
      repeat (n) @(posedge i_mclk);
      #1 chk("oe_b in reset", {2'h0, oe_b}, 5'h07);
      chk("valid in reset", {4'h0, valid}, 5'h00);
      @(posedge i_mclk) i_rst_b <= 1'b1;
      @(posedge i_mclk);
      #1 chk("oe_b after reset", {2'h0, oe_b}, 5'h00);
      chk("valid after reset", {4'h0, valid}, 5'h01);
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial
   begin
      hw_reset(3'h0, 20);
      $display("power-on reset test done");
      foreach (rows[i])
      begin
         hw_reset(rows[i][13:11], 3);
         chk("address", addr, rows[i][7:3]);
         @(posedge i_mclk) stat <= rows[i][10:8];
         repeat (2) @(posedge i_mclk);
         #1 chk("led drive", {2'h0, drv}, {2'h0, rows[i][2:0]});
         $display("row %0d done", i);
      end
      // software reset and a moved strap level must leave everything alone
      @(posedge i_mclk) i_sw_reset <= 1'b1;
      strap <= 3'h5;
      stat <= 3'h0;
      repeat (3) @(posedge i_mclk);
      #1 chk("address kept", addr, 5'h08);
      chk("oe_b in sw reset", {2'h0, oe_b}, 5'h00);
      chk("inactive led", {2'h0, drv}, 5'h02);
      @(posedge i_mclk) i_sw_reset <= 1'b0;
      $display("software reset test done");
      hw_reset(3'h3, 2);
      chk("resampled address", addr, 5'h0C);
      $display("second hardware reset test done");
      tally_and_finish();
   end
endmodule
